/* hw/adc_seq_ctrl.sv */
// Converter control and status block with an AHB-Lite register slave
//
// Notes on behaviour
// - Channel field codes 0 to 7 route analog inputs 0 to 7.
// - Bits 5 to 3 choose which shared port lines are analog.
// - Analog lines lose digital function and pull-up; converter powers up.
// - All-zero port configuration powers the converter off.
// - Start rising resets the converter and sets the not-done flag.
// - Conversion begins only after start rises and then falls.
// - Not-done flag, bit 6, clears when a conversion finishes.
// - Result bytes are read-only; writes to them do nothing.
// - Clock select 00, 01, 10 divide by 2, 8, 32; 11 undefined.
// - Clock register bits 2 to 6 always read zero.
// - Low byte holds result 3..0 in bits 7..4; high byte 11..4.
`include "conv_map.svh"
`timescale 1ns/1ps
`default_nettype none
module adc_seq_ctrl import conv_pkg::*; #(
    parameter int WIDTH = 12,
    parameter int LINES = 8,
    parameter int SAMPLE_TICKS = `SAMPLE_TICKS_DEF
) (
    input wire logic clock, // System clock, 125 MHz
    input wire logic rst, // Synchronous reset, active high
    input wire logic hsel, // Slave select
    input wire logic [31:0] haddr, // Byte address
    input wire logic [1:0] htrans, // Transfer type
    input wire logic hwrite, // Write when high
    input wire logic [2:0] hsize, // Transfer size, word only
    input wire logic [31:0] hwdata, // Write data
    input wire logic hready, // Bus ready
    output logic hreadyout, // Slave ready
    output logic [31:0] hrdata, // Read data
    output logic hresp, // Always OKAY
    input wire logic comp_hi, // Comparator: input at or above trial code
    output logic [2:0] chan_sel, // Analog input routed to converter
    output logic [LINES-1:0] analog_mode, // Line is analog, digital and pull-up off
    output logic conv_power, // Converter powered
    output logic sample_en, // Sample switch closed
    output logic [WIDTH-1:0] dac_code, // Trial code to comparator DAC
    output logic irq // Level interrupt
);
    generate
        if (WIDTH != 12 || LINES != 8) begin : g_bad
            $error("adc_seq_ctrl: register layout needs 12 bits and 8 lines");
        end
    endgenerate

    // Bus phase state
    bus_phase_t phase_q;
    logic wr_pend_q;
    logic hreadyout_q;
    logic hresp_q;
    logic [31:0] hrdata_q;
    logic [7:0] rd_val;
    logic addr_ok;
    logic take;

    // Register state
    ctrl_reg_t ctrl_q;
    clksel_reg_t clksel_q;
    logic [WIDTH-1:0] result_q;
    logic [1:0] irq_stat_q;
    logic [1:0] irq_mask_q;
    logic irq_q;

    // Pin state
    logic [2:0] chan_q;
    logic [LINES-1:0] analog_q;
    logic power_q;
    logic sample_q;

    // Divider and engine
    logic [4:0] div_cnt_q;
    logic [4:0] div_last;
    logic tick;
    logic eng_busy, eng_done, eng_sample;
    logic [WIDTH-1:0] eng_dac, eng_result;

    // Write decode
    logic wr_ctrl, wr_clk, wr_stat, wr_mask;
    ctrl_reg_t wctrl;
    logic start_rise, start_fall;

    // Address phase is taken when selected, active and the bus is ready
    assign addr_ok = (haddr[31:10] == 22'h0) && (haddr[1:0] == 2'h0);
    assign take = hsel && hready && (htrans == `HTRANS_NONSEQ || htrans == `HTRANS_SEQ);

    // Capture the address phase for a write in the next cycle
    always_ff @(posedge clock) begin
        if (rst) begin
            wr_pend_q <= 1'b0;
            phase_q <= '0;
        end else if (hready) begin
            wr_pend_q <= take && hwrite && addr_ok;
            phase_q.wr <= take && hwrite;
            phase_q.idx <= haddr[9:2];
        end
    end

    // Zero wait states and an OKAY answer to every access
    always_ff @(posedge clock) begin
        if (rst) begin
            hreadyout_q <= 1'b1;
            hresp_q <= 1'b0;
        end else begin
            hreadyout_q <= 1'b1;
            hresp_q <= 1'b0;
        end
    end

    // Read value of the indexed register; unmapped reads as zero
    always_comb begin
        unique case (haddr[9:2])
            `IDX_RESULT_LOW: rd_val = {result_q[3:0], 4'h0};
            `IDX_RESULT_HIGH: rd_val = result_q[11:4];
            `IDX_CONTROL: rd_val = ctrl_q;
            `IDX_CLOCK_SEL: rd_val = {clksel_q.test, 5'h00, clksel_q.div};
            `IDX_IRQ_STATUS: rd_val = {6'h00, irq_stat_q};
            `IDX_IRQ_MASK: rd_val = {6'h00, irq_mask_q};
            default: rd_val = 8'h00;
        endcase
    end

    // Read data is registered at the address edge and stands in the data phase
    always_ff @(posedge clock) begin
        if (rst) hrdata_q <= 32'h0;
        else if (take && !hwrite && addr_ok) hrdata_q <= {24'h0, rd_val};
        else if (hready) hrdata_q <= 32'h0;
    end

    // Data phase write strobes; result bytes have no strobe at all
    assign wr_ctrl = wr_pend_q && phase_q.idx == `IDX_CONTROL;
    assign wr_clk = wr_pend_q && phase_q.idx == `IDX_CLOCK_SEL;
    assign wr_stat = wr_pend_q && phase_q.idx == `IDX_IRQ_STATUS;
    assign wr_mask = wr_pend_q && phase_q.idx == `IDX_IRQ_MASK;
    assign wctrl = ctrl_reg_t'(hwdata[7:0]);

    // Start bit edges seen in the written value
    assign start_rise = wr_ctrl && wctrl.start && !ctrl_q.start;
    assign start_fall = wr_ctrl && !wctrl.start && ctrl_q.start;

    // Control register: software fields, and the not-done flag set by a start
    // rise and cleared at completion; one process so the struct has one driver
    always_ff @(posedge clock) begin
        if (rst) begin
            ctrl_q <= ctrl_reg_t'(`CONTROL_RESET);
        end else begin
            if (wr_ctrl) begin
                ctrl_q.start <= wctrl.start;
                ctrl_q.port_cfg <= wctrl.port_cfg;
                ctrl_q.chan <= wctrl.chan;
            end
            if (start_rise) ctrl_q.done_n <= 1'b1;
            else if (eng_done) ctrl_q.done_n <= 1'b0;
        end
    end

    // Clock select and test bits; unused bits are not stored
    always_ff @(posedge clock) begin
        if (rst) begin
            clksel_q.div <= 2'(`CLOCK_SEL_RESET);
            clksel_q.test <= 1'b0;
        end else if (wr_clk) begin
            clksel_q.div <= hwdata[1:0];
            clksel_q.test <= hwdata[`CLKSEL_TEST_BIT]; // Stored, no effect
        end
    end

    // Divider terminal count; the undefined code behaves as divide by 32
    always_comb begin
        unique case (clksel_q.div)
            `CLKSEL_DIV2: div_last = `DIV2_LAST;
            `CLKSEL_DIV8: div_last = `DIV8_LAST;
            `CLKSEL_DIV32: div_last = `DIV32_LAST;
            default: div_last = `DIV32_LAST;
        endcase
    end

    // Converter clock tick, restarted with each conversion for even timing
    always_ff @(posedge clock) begin
        if (rst || start_fall || start_rise) div_cnt_q <= 5'h00;
        else if (div_cnt_q >= div_last) div_cnt_q <= 5'h00;
        else div_cnt_q <= div_cnt_q + 5'h01;
    end
    assign tick = (div_cnt_q == div_last);

    // Conversion engine: rise aborts it, fall starts it
    sar_engine #(
        .WIDTH(WIDTH),
        .SAMPLE_TICKS(SAMPLE_TICKS)
    ) u_engine (
        .clock(clock),
        .rst(rst),
        .abort(start_rise),
        .go(start_fall),
        .tick(tick),
        .comp_hi(comp_hi),
        .busy(eng_busy),
        .done(eng_done),
        .sample_en(eng_sample),
        .dac_code(eng_dac),
        .result(eng_result)
    );

    // Both result bytes load together at completion and hold after
    always_ff @(posedge clock) begin
        if (rst) result_q <= '0;
        else if (eng_done) result_q <= eng_result;
    end

    // Channel routing to the multiplexer
    always_ff @(posedge clock) begin
        if (rst) chan_q <= 3'h0;
        else chan_q <= ctrl_q.chan;
    end

    // Per-line analog mode: configuration n makes lines below n analog; configuration 7 makes all lines analog
    genvar gi;
    generate
        for (gi = 0; gi < LINES; gi++) begin : g_line
            always_ff @(posedge clock) begin
                if (rst) analog_q[gi] <= 1'b0;
                else analog_q[gi] <= (ctrl_q.port_cfg == `CFG_ALL_ANALOG)
                    || (gi < int'(ctrl_q.port_cfg));
            end
        end
    endgenerate

    // Sample switch output registered so the pin comes from a flip-flop
    always_ff @(posedge clock) begin
        if (rst) sample_q <= 1'b0;
        else sample_q <= eng_sample;
    end

    // Converter power follows any analog line
    always_ff @(posedge clock) begin
        if (rst) power_q <= 1'b0;
        else power_q <= (ctrl_q.port_cfg != `CFG_ALL_DIGITAL);
    end

    // Interrupt status: set wins over a write-one clear
    always_ff @(posedge clock) begin
        if (rst) irq_stat_q <= `IRQ_RESET;
        else begin
            irq_stat_q <= (irq_stat_q & ~(wr_stat ? hwdata[1:0] : 2'h0))
                | {start_rise && eng_busy, eng_done};
        end
    end

    // Interrupt mask
    always_ff @(posedge clock) begin
        if (rst) irq_mask_q <= `IRQ_RESET;
        else if (wr_mask) irq_mask_q <= hwdata[1:0];
    end

    // Interrupt level from masked status
    always_ff @(posedge clock) begin
        if (rst) irq_q <= 1'b0;
        else irq_q <= |(irq_stat_q & irq_mask_q);
    end

    // Outputs straight from flip-flops
    assign hreadyout = hreadyout_q;
    assign hresp = hresp_q;
    assign hrdata = hrdata_q;
    assign chan_sel = chan_q;
    assign analog_mode = analog_q;
    assign conv_power = power_q;
    assign sample_en = sample_q;
    assign dac_code = eng_dac;
    assign irq = irq_q;
endmodule // adc_seq_ctrl
`default_nettype wire

/* hw/sar_engine.sv */
// Successive-approximation sequencer driven by converter clock ticks
`include "conv_map.svh"
`timescale 1ns/1ps
`default_nettype none
module sar_engine import conv_pkg::*; #(
    parameter int WIDTH = 12,
    parameter int SAMPLE_TICKS = `SAMPLE_TICKS_DEF
) (
    input wire logic clock, // System clock
    input wire logic rst, // Synchronous reset
    input wire logic abort, // Reset the converter
    input wire logic go, // Begin a conversion
    input wire logic tick, // Converter clock tick
    input wire logic comp_hi, // Input at or above trial code
    output logic busy, // Conversion running
    output logic done, // One-cycle end pulse
    output logic sample_en, // Sample switch closed
    output logic [WIDTH-1:0] dac_code, // Trial code
    output logic [WIDTH-1:0] result // Last result
);
    localparam int BW = $clog2(WIDTH);
    localparam int TW = $clog2(SAMPLE_TICKS + 1);
    sar_state_t state_q;
    logic [BW-1:0] bit_q;
    logic [TW-1:0] ticks_q;
    logic [WIDTH-1:0] dac_q, res_q, trial;
    logic done_q;

    generate
        if (SAMPLE_TICKS < 1 || WIDTH < 2) begin : g_bad
            $error("sar_engine: unsupported parameters");
        end
    endgenerate

    // Resolve the current bit and set the next trial bit
    always_comb begin
        trial = dac_q;
        if (!comp_hi) trial[bit_q] = 1'b0;
        if (bit_q != '0) trial[bit_q - 1'b1] = 1'b1;
    end

    // Sequence sampling then one bit per tick; abort beats everything
    always_ff @(posedge clock) begin
        done_q <= 1'b0;
        if (rst || abort) begin
            state_q <= SAR_IDLE;
            ticks_q <= '0;
            bit_q <= '0;
            dac_q <= '0;
        end else begin
            unique case (state_q)
                SAR_IDLE: if (go) begin
                    state_q <= SAR_SAMPLE;
                    ticks_q <= '0;
                end
                SAR_SAMPLE: if (tick) begin
                    if (ticks_q == TW'(SAMPLE_TICKS - 1)) begin
                        state_q <= SAR_CONVERT;
                        bit_q <= BW'(WIDTH - 1);
                        dac_q <= {1'b1, {(WIDTH-1){1'b0}}};
                    end else ticks_q <= ticks_q + 1'b1;
                end
                SAR_CONVERT: if (tick) begin
                    dac_q <= trial;
                    if (bit_q == '0) begin
                        state_q <= SAR_IDLE;
                        done_q <= 1'b1;
                    end else bit_q <= bit_q - 1'b1;
                end
            endcase
        end
    end

    // Hold the finished code until the next completion
    always_ff @(posedge clock) begin
        if (rst) res_q <= '0;
        else if (state_q == SAR_CONVERT && tick && bit_q == '0 && !abort) res_q <= trial;
    end

    assign busy = (state_q != SAR_IDLE);
    assign done = done_q;
    assign sample_en = (state_q == SAR_SAMPLE);
    assign dac_code = dac_q;
    assign result = res_q;
endmodule // sar_engine
`default_nettype wire

/* pkg/conv_map.svh */
// Register indexes, field positions, reset values and divider counts of the converter block
`ifndef CONV_MAP_SVH
`define CONV_MAP_SVH
// Register indexes; the bus byte address is four times the index
`define IDX_RESULT_LOW 8'h24
`define IDX_RESULT_HIGH 8'h25
`define IDX_CONTROL 8'h26
`define IDX_CLOCK_SEL 8'h27
`define IDX_IRQ_STATUS 8'h28
`define IDX_IRQ_MASK 8'h29
// Reset values
`define CONTROL_RESET 8'h00
`define CLOCK_SEL_RESET 8'h00
`define IRQ_RESET 2'h0
// Field positions
`define CTRL_START_BIT 7
`define CLKSEL_TEST_BIT 7
`define IRQ_DONE_BIT 0
`define IRQ_ABORT_BIT 1
// Clock select codes and terminal counts of the divider
`define CLKSEL_DIV2 2'h0
`define CLKSEL_DIV8 2'h1
`define CLKSEL_DIV32 2'h2
`define DIV2_LAST 5'h01
`define DIV8_LAST 5'h07
`define DIV32_LAST 5'h1F
// Port configurations that make every line analog and every line digital
`define CFG_ALL_ANALOG 3'h7
`define CFG_ALL_DIGITAL 3'h0
// Bus transfer codes
`define HTRANS_NONSEQ 2'h2
`define HTRANS_SEQ 2'h3
// Default converter clock ticks spent sampling
`define SAMPLE_TICKS_DEF 4
`endif

/* pkg/conv_pkg.sv */
// Types shared by the converter control block and its conversion engine
package conv_pkg;
    // Converter control register layout
    typedef struct packed {
        logic start;
        logic done_n;
        logic [2:0] port_cfg;
        logic [2:0] chan;
    } ctrl_reg_t;
    // Stored part of the converter clock register
    typedef struct packed {
        logic test;
        logic [1:0] div;
    } clksel_reg_t;
    // Captured bus address phase
    typedef struct packed {
        logic wr;
        logic [7:0] idx;
    } bus_phase_t;
    // Engine state
    typedef enum logic [1:0] {SAR_IDLE, SAR_SAMPLE, SAR_CONVERT} sar_state_t;
endpackage

/* tb/adc_seq_chk.sv */
// Bus and converter output checker bound to the control block
`timescale 1ns/1ps
`default_nettype none
module adc_seq_chk #(
    parameter int WIDTH = 12,
    parameter int LINES = 8,
    parameter int SAMPLE_TICKS = 4
) (
    input wire logic clock, // Clock
    input wire logic rst, // Reset
    input wire logic hsel, // Select
    input wire logic [31:0] haddr, // Address
    input wire logic [1:0] htrans, // Transfer
    input wire logic hwrite, // Write
    input wire logic [2:0] hsize, // Size
    input wire logic [31:0] hwdata, // Write data
    input wire logic hready, // Ready in
    input wire logic hreadyout, // Ready out
    input wire logic [31:0] hrdata, // Read data
    input wire logic hresp, // Response
    input wire logic comp_hi, // Comparator
    input wire logic [2:0] chan_sel, // Channel
    input wire logic [LINES-1:0] analog_mode, // Analog lines
    input wire logic conv_power, // Power
    input wire logic sample_en, // Sampling
    input wire logic [WIDTH-1:0] dac_code, // Trial code
    input wire logic irq // Interrupt
);
    logic ap_q;
    logic aw_q;
    logic [31:0] aa_q;
    logic [7:0] wd_q;
    logic ctrl_wr;
    // Data phase of a control register write
    assign ctrl_wr = ap_q && aw_q && aa_q == 32'h98;
    // Address phase seen and last control value written
    always_ff @(posedge clock) begin
        if (rst) begin
            ap_q <= 1'b0;
            wd_q <= 8'h00;
        end else begin
            ap_q <= hsel && hready && htrans[1];
            if (ctrl_wr) begin
                wd_q <= hwdata[7:0];
            end
        end
    end
    // Address and direction of the transfer now in its data phase
    always_ff @(posedge clock) begin
        aw_q <= hwrite;
        aa_q <= haddr;
    end
    // Lines made analog by a configuration code
    function automatic logic [LINES-1:0] therm(input logic [2:0] n);
        therm = (n == 3'h7) ? {LINES{1'b1}} : LINES'((32'h1 << n) - 32'h1);
    endfunction
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (rst);
    sequence s_ctrl_wr;
        ctrl_wr;
    endsequence
    sequence s_start_rise;
        ctrl_wr && hwdata[7] && !wd_q[7];
    endsequence
    a_chan_follow: assert property (s_ctrl_wr |=> ##[0:1] chan_sel == wd_q[2:0])
        else $error("channel select does not follow control write");
    a_cfg_follow: assert property (s_ctrl_wr |=> ##[0:1] analog_mode == therm(wd_q[5:3]))
        else $error("analog lines do not follow port configuration");
    a_analog_power: assert property (analog_mode != '0 |-> conv_power)
        else $error("analog line while converter unpowered");
    a_power_off: assert property (analog_mode == '0 |-> !conv_power)
        else $error("converter powered with no analog line");
    a_abort_idle: assert property (s_start_rise |=> ##[0:1] !sample_en)
        else $error("sampling continues after start rise");
    a_run_start_low: assert property ($rose(sample_en) |-> !wd_q[7])
        else $error("conversion began while start is high");
    a_clock_zero: assert property (ap_q && !aw_q && aa_q == 32'h9C |->
        hrdata[6:2] == 5'h00 && hrdata[31:8] == 24'h000000)
        else $error("clock register unused bits not zero");
    a_low_nibble: assert property (ap_q && !aw_q && aa_q == 32'h90 |-> hrdata[3:0] == 4'h0)
        else $error("result low byte lower nibble not zero");
endmodule // adc_seq_chk
bind adc_seq_ctrl adc_seq_chk #(.WIDTH(WIDTH), .LINES(LINES), .SAMPLE_TICKS(SAMPLE_TICKS)) chk (
    .clock(clock), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .comp_hi(comp_hi),
    .chan_sel(chan_sel), .analog_mode(analog_mode), .conv_power(conv_power),
    .sample_en(sample_en), .dac_code(dac_code), .irq(irq));
`default_nettype wire

/* tb/adc_seq_ctrl_tb.sv */
// Self-checking bench for the converter control block
`timescale 1ns/1ps
`default_nettype none
module adc_seq_ctrl_tb;
    logic clock = 1'b0;
    logic rst = 1'b1;
    logic hsel = 1'b0;
    logic hwrite = 1'b0;
    logic slow = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [31:0] hwdata = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic [2:0] hsize = 3'h2;
    logic [95:0] levels = 96'h0;
    logic hreadyout, hresp, comp_hi, conv_power, sample_en, irq;
    logic [31:0] hrdata;
    logic [31:0] rd;
    logic [2:0] chan_sel;
    logic [7:0] analog_mode;
    logic [11:0] dac_code;
    int fail_count = 0;
    int checked = 0;
    int cyc = 0;
    int m_stat = 0;
    int m_mask = 0;
    int m_res = 0;
    adc_seq_ctrl #(.SAMPLE_TICKS(1)) dut (.clock(clock), .rst(rst), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
        .comp_hi(comp_hi), .chan_sel(chan_sel), .analog_mode(analog_mode),
        .conv_power(conv_power), .sample_en(sample_en), .dac_code(dac_code), .irq(irq));
    analog_mux_model mux (.clock(clock), .chan_sel(chan_sel), .analog_mode(analog_mode),
        .conv_power(conv_power), .dac_code(dac_code), .levels(levels), .slow(slow),
        .comp_hi(comp_hi));
    // Clock and cycle count
    initial begin
        forever #4 clock = ~clock;
    end
    always @(posedge clock) cyc <= cyc + 1;
    // One single bus transfer; read data taken at the edge ending the data phase
    task automatic xfer(input logic [31:0] a, input logic w, input logic [7:0] d);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= 2'h2;
        hwrite <= w;
        do @(posedge clock); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= {24'h0, d};
        do @(posedge clock); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask
    task automatic check(input string n, input logic [31:0] e, input logic [31:0] g);
        checked++;
        if (g !== e) begin
            $display("mismatch %s expected %h seen %h", n, e, g);
            fail_count++;
        end
    endtask
    task automatic rdchk(input logic [31:0] a, input logic [31:0] e, input string n);
        xfer(a, 1'b0, 8'h00);
        check(n, e, rd);
        check("hresp", 32'h0, {31'h0, hresp});
    endtask
    // Full conversion on one channel, optionally aborted once by a start rise landing 10 cycles after the start fall
    task automatic convert(input int ch, input int dv, input bit ab);
        logic [7:0] c;
        logic [11:0] v;
        int n;
        int t0;
        int dd;
        c = {5'h07, ch[2:0]};
        v = 12'($urandom);
        dd = (dv == 0) ? 2 : (dv == 1) ? 8 : 32;
        levels[ch*12 +: 12] <= v;
        slow <= dv[1];
        xfer(32'h9C, 1'b1, 8'(dv));
        xfer(32'h98, 1'b1, c & 8'h38);
        xfer(32'h98, 1'b1, c);
        xfer(32'h98, 1'b1, c | 8'h80);
        rdchk(32'h98, {24'h0, c | 8'hC0}, "flag_set");
        xfer(32'h98, 1'b1, c);
        if (ab) begin
            repeat (8) @(posedge clock);
            xfer(32'h98, 1'b1, c | 8'h80);
            m_stat = m_stat | 2;
            rdchk(32'h94, {24'h0, m_res[11:4]}, "held_high");
            xfer(32'h98, 1'b1, c);
        end
        t0 = cyc;
        n = 0;
        do begin
            xfer(32'h98, 1'b0, 8'h00);
            n++;
        end while (rd[6] !== 1'b0 && n < 600);
        check("flag_clear", {24'h0, c}, rd);
        check("conv_time", 1, (cyc - t0 >= 13 * dd) && (cyc - t0 <= 13 * dd + 12));
        m_res = v;
        m_stat = m_stat | 1;
        rdchk(32'h94, {24'h0, m_res[11:4]}, "result_high");
        rdchk(32'h90, {24'h0, m_res[3:0], 4'h0}, "result_low");
        check("irq", (m_stat & m_mask) != 0, irq);
    endtask
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    // Hang guard
    initial begin
        repeat (40000) @(posedge clock);
        fail_count++;
        wrap_up();
    end
    initial begin
        void'($urandom(59));
        repeat (5) @(posedge clock);
        rst <= 1'b0;
        @(posedge clock);
        for (int a = 'h90; a <= 'hA8; a += 4) begin
            rdchk(32'(a), 32'h0, "reset_value");
        end
        $display("test reset done");
        xfer(32'h9C, 1'b1, 8'h7F);
        rdchk(32'h9C, 32'h03, "clock_select");
        xfer(32'h90, 1'b1, 8'hFF);
        xfer(32'h94, 1'b1, 8'hFF);
        rdchk(32'h90, 32'h0, "result_low_ro");
        rdchk(32'h94, 32'h0, "result_high_ro");
        $display("test access done");
        for (int n = 0; n < 8; n++) begin
            xfer(32'h98, 1'b1, 8'((n << 3) | (7 - n)));
            repeat (2) @(posedge clock);
            check("analog_mode", (n == 7) ? 8'hFF : 8'((1 << n) - 1), analog_mode);
            check("conv_power", n != 0, conv_power);
            check("chan_sel", 7 - n, chan_sel);
        end
        $display("test port config done");
        xfer(32'hA4, 1'b1, 8'h01);
        m_mask = 1;
        for (int i = 0; i < 8; i++) begin
            convert(i, i % 4, i == 5);
        end
        rdchk(32'hA0, m_stat, "irq_status");
        xfer(32'hA0, 1'b1, 8'h03);
        m_stat = 0;
        xfer(32'hA4, 1'b1, 8'h00);
        m_mask = 0;
        check("irq_clear", 0, irq);
        convert(2, 0, 0);
        rdchk(32'hA0, 32'h1, "irq_status_masked");
        $display("test conversions done");
        wrap_up();
    end
endmodule // adc_seq_ctrl_tb
`default_nettype wire

/* tb/analog_mux_model.sv */
// Analog input multiplexer and comparator standing beside the converter
`timescale 1ns/1ps
`default_nettype none
module analog_mux_model #(
    parameter int WIDTH = 12
) (
    input wire logic clock, // Clock
    input wire logic [2:0] chan_sel, // Routed input
    input wire logic [7:0] analog_mode, // Analog lines
    input wire logic conv_power, // Powered
    input wire logic [WIDTH-1:0] dac_code, // Trial code
    input wire logic [8*WIDTH-1:0] levels, // Input levels
    input wire logic slow, // Late comparator
    output logic comp_hi // Comparison
);
    logic now_hi;
    logic late_q = 1'b0;
    logic junk_q = 1'b0;
    // Only a powered converter on an analog line compares; otherwise noise
    assign now_hi = (conv_power && analog_mode[chan_sel]) ?
        (levels[chan_sel*WIDTH +: WIDTH] >= dac_code) : junk_q;
    // Settling delay and toggling noise
    always @(posedge clock) begin
        late_q <= now_hi;
        junk_q <= !junk_q;
    end
    assign comp_hi = slow ? late_q : now_hi;
endmodule // analog_mux_model
`default_nettype wire
